// >>> lpm_pkg.sv
// Shared constants and types for the panel and host pin function map
`default_nettype none
package lpm_pkg;
   typedef enum logic [2:0] {
      LPM_BUS_EMB1, LPM_BUS_EMB2, LPM_BUS_STB1, LPM_BUS_STB2, LPM_BUS_GEN1, LPM_BUS_GEN2, LPM_BUS_RSVD
   } lpm_bus_e;
   localparam int LPM_AW = 8;
   localparam int LPM_DW = 8;
   localparam int LPM_IO_W = 5;
   localparam int LPM_STRAP_W = 5;
   localparam int LPM_PIX_LOW_W = 8;
   localparam int LPM_PIX_MID_W = 3;
   localparam logic [7:0] LPM_REG_MODE3 = 8'h03;
   localparam logic [7:0] LPM_REG_IO_DIR = 8'h04;
   localparam logic [7:0] LPM_REG_IO_DATA = 8'h05;
   localparam logic [7:0] LPM_REG_STATUS = 8'h06;
   localparam logic [7:0] LPM_MODE3_RST = 8'h00;
   localparam logic [7:0] LPM_MODE3_WMASK = 8'h77;
   localparam int LPM_M3_PANEL_LSB = 0;
   localparam int LPM_M3_PS_SEL = 2;
   localparam int LPM_M3_DISP_ON = 4;
   localparam int LPM_M3_INV_SEL = 5;
   localparam int LPM_M3_PWR_ON = 6;
   localparam logic [1:0] LPM_PANEL_MONO = 2'h0;
   localparam logic [1:0] LPM_PANEL_SHIFT2 = 2'h1;
   localparam logic [1:0] LPM_PANEL_TFT = 2'h2;
   localparam int LPM_STRAP_BE = 3;
   localparam int LPM_STRAP_POL = 4;
   localparam logic [2:0] LPM_CNF_EMB2 = 3'h0;
   localparam logic [2:0] LPM_CNF_EMB1 = 3'h1;
   localparam logic [2:0] LPM_CNF_STB1 = 3'h3;
   localparam logic [2:0] LPM_CNF_STB2 = 3'h5;
   localparam logic [2:0] LPM_CNF_GEN = 3'h7;
   localparam int LPM_IO_PS = 0;
   localparam int LPM_IO_MID_LSB = 1;
   localparam int LPM_IO_ELEVEN = 4;
endpackage
`default_nettype wire

// >>> lpm_strap_latch.sv
// Captures the configuration straps once after reset release and decodes them
`default_nettype none
module lpm_strap_latch
   import lpm_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [LPM_STRAP_W-1:0] i_config_straps,
   input wire logic i_bus_start_n,
   output lpm_bus_e o_mode,
   output logic o_big_endian,
   output logic o_pwr_polarity,
   output logic o_valid
);
   function automatic lpm_bus_e decode(input logic [2:0] code, input logic bs_n);
      unique case (code)
         LPM_CNF_EMB2: decode = LPM_BUS_EMB2;
         LPM_CNF_EMB1: decode = LPM_BUS_EMB1;
         LPM_CNF_STB1: decode = LPM_BUS_STB1;
         LPM_CNF_STB2: decode = LPM_BUS_STB2;
         LPM_CNF_GEN: decode = bs_n ? LPM_BUS_GEN2 : LPM_BUS_GEN1;
         default: decode = LPM_BUS_RSVD;
      endcase
   endfunction

   // Straps are sampled on the first edge after release, never under the async reset
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_mode <= LPM_BUS_RSVD;
         o_big_endian <= 1'b0;
         o_pwr_polarity <= 1'b0;
      end else if (!o_valid) begin
         o_valid <= 1'b1;
         o_mode <= decode(i_config_straps[2:0], i_bus_start_n);
         o_big_endian <= i_config_straps[LPM_STRAP_BE];
         o_pwr_polarity <= i_config_straps[LPM_STRAP_POL];
      end
   end
endmodule
`default_nettype wire

// >>> lpm_io_bit.sv
// One shared pin: software I/O bit with a function override
`default_nettype none
module lpm_io_bit (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_func_sel,
   input wire logic i_func_out,
   input wire logic i_func_oe,
   input wire logic i_wr_dir,
   input wire logic i_wr_data,
   input wire logic i_wdata_bit,
   input wire logic i_pad_in,
   output logic o_pad_out,
   output logic o_pad_oe,
   output logic o_dir,
   output logic o_in
);
   logic out_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_dir <= 1'b0;
         out_r <= 1'b0;
      end else begin
         if (i_wr_dir) begin
            o_dir <= i_wdata_bit;
         end
         if (i_wr_data) begin
            out_r <= i_wdata_bit;
         end
      end
   end

   // Pin comes out of reset as an input
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_pad_out <= 1'b0;
         o_pad_oe <= 1'b0;
         o_in <= 1'b0;
      end else begin
         o_pad_out <= i_func_sel ? i_func_out : out_r;
         o_pad_oe <= i_func_sel ? i_func_oe : o_dir;
         o_in <= i_pad_in;
      end
   end
endmodule
`default_nettype wire

// >>> lpm_pin_map.sv
// Host and panel pin function map with reset states and configuration straps
`default_nettype none
module lpm_pin_map
   import lpm_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [LPM_AW-1:0] i_reg_addr,
   input wire logic [LPM_DW-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [LPM_DW-1:0] o_reg_rdata,
   input wire logic [LPM_STRAP_W-1:0] i_config_straps,
   input wire logic i_bus_start_n,
   input wire logic i_test_mode_enable,
   input wire logic i_cs_n,
   input wire logic i_read_pin,
   input wire logic i_core_ready,
   output logic o_read_strobe_n,
   output logic o_low_byte_read_n,
   output logic o_bus_size_bit_one,
   output logic o_wait_out,
   output logic o_wait_oe,
   output lpm_bus_e o_bus_mode,
   output logic o_big_endian,
   input wire logic [LPM_PIX_LOW_W-1:0] i_pixel_low,
   input wire logic [LPM_PIX_MID_W-1:0] i_pixel_mid,
   input wire logic i_pixel_eleven,
   input wire logic i_frame,
   input wire logic i_line,
   input wire logic i_shift,
   input wire logic i_display_enable,
   input wire logic i_backplane_bias,
   input wire logic i_second_shift,
   output logic [LPM_PIX_LOW_W-1:0] o_panel_pixel_bits_low,
   output logic o_panel_frame_pulse,
   output logic o_panel_line_pulse,
   output logic o_panel_shift_clock,
   output logic o_panel_display_ready,
   output logic o_panel_power_control,
   input wire logic [LPM_IO_W-1:0] i_io_pad_in,
   output logic [LPM_IO_W-1:0] o_io_pad_out,
   output logic [LPM_IO_W-1:0] o_io_pad_oe,
   output logic o_inverse_video,
   output logic o_power_save_req
);
   logic [LPM_DW-1:0] mode3_r;
   logic [LPM_IO_W-1:0] func_sel;
   logic [LPM_IO_W-1:0] func_out;
   logic [LPM_IO_W-1:0] func_oe;
   logic [LPM_IO_W-1:0] io_dir;
   logic [LPM_IO_W-1:0] io_in;
   logic strap_valid;
   logic pwr_pol;
   logic pwr_on_r;
   logic test_seen_r;
   logic host_active;
   logic ack_style;
   logic disp_on;
   logic is_tft;
   logic [1:0] panel_type;
   logic wr_mode3;
   logic wr_dir;
   logic wr_data;

   assign panel_type = mode3_r[LPM_M3_PANEL_LSB +: 2];
   assign disp_on = mode3_r[LPM_M3_DISP_ON];
   assign is_tft = (panel_type == LPM_PANEL_TFT);
   assign wr_mode3 = i_reg_wr && (i_reg_addr == LPM_REG_MODE3);
   assign wr_dir = i_reg_wr && (i_reg_addr == LPM_REG_IO_DIR);
   assign wr_data = i_reg_wr && (i_reg_addr == LPM_REG_IO_DATA);

   lpm_strap_latch u_straps (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_config_straps(i_config_straps),
      .i_bus_start_n(i_bus_start_n),
      .o_mode(o_bus_mode),
      .o_big_endian(o_big_endian),
      .o_pwr_polarity(pwr_pol),
      .o_valid(strap_valid)
   );

   // Software registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mode3_r <= LPM_MODE3_RST;
      end else if (wr_mode3) begin
         mode3_r <= i_reg_wdata & LPM_MODE3_WMASK;
      end
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            LPM_REG_MODE3: o_reg_rdata <= mode3_r;
            LPM_REG_IO_DIR: o_reg_rdata <= {3'h0, io_dir};
            LPM_REG_IO_DATA: o_reg_rdata <= {3'h0, io_in};
            LPM_REG_STATUS: o_reg_rdata <= {strap_valid, test_seen_r, o_power_save_req, pwr_pol,
                                            o_big_endian, o_bus_mode};
            default: o_reg_rdata <= '0;
         endcase
      end else begin
         o_reg_rdata <= '0;
      end
   end

   // Test enable is only reported; no test behaviour exists
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         test_seen_r <= 1'b0;
      end else begin
         test_seen_r <= i_test_mode_enable;
      end
   end

   // Read pin role per bus mode
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_read_strobe_n <= 1'b1;
         o_low_byte_read_n <= 1'b1;
         o_bus_size_bit_one <= 1'b0;
      end else begin
         o_read_strobe_n <= 1'b1;
         o_low_byte_read_n <= 1'b1;
         o_bus_size_bit_one <= 1'b0;
         unique case (o_bus_mode)
            LPM_BUS_EMB1, LPM_BUS_EMB2, LPM_BUS_GEN2: o_read_strobe_n <= i_read_pin;
            LPM_BUS_STB2: o_bus_size_bit_one <= i_read_pin;
            LPM_BUS_GEN1: o_low_byte_read_n <= i_read_pin;
            LPM_BUS_STB1, LPM_BUS_RSVD: o_read_strobe_n <= 1'b1;
         endcase
      end
   end

   // Wait pin: acknowledge low when the core is ready in EMB2, STB1 and STB2, else wait request low when not ready
   assign host_active = strap_valid && !i_cs_n && (o_bus_mode != LPM_BUS_RSVD);
   assign ack_style = (o_bus_mode == LPM_BUS_EMB2) || (o_bus_mode == LPM_BUS_STB1) ||
                      (o_bus_mode == LPM_BUS_STB2);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_wait_out <= 1'b1;
         o_wait_oe <= 1'b0;
      end else begin
         o_wait_oe <= host_active;
         if (!host_active) begin
            o_wait_out <= 1'b1;
         end else if (ack_style) begin
            o_wait_out <= !i_core_ready;
         end else begin
            o_wait_out <= i_core_ready;
         end
      end
   end

   // Panel outputs held low until display output is enabled
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_panel_pixel_bits_low <= '0;
         o_panel_frame_pulse <= 1'b0;
         o_panel_line_pulse <= 1'b0;
         o_panel_shift_clock <= 1'b0;
      end else begin
         o_panel_pixel_bits_low <= disp_on ? i_pixel_low : '0;
         o_panel_frame_pulse <= disp_on && i_frame;
         o_panel_line_pulse <= disp_on && i_line;
         o_panel_shift_clock <= disp_on && i_shift;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_panel_display_ready <= 1'b0;
      end else if (!disp_on) begin
         o_panel_display_ready <= 1'b0;
      end else if (is_tft) begin
         o_panel_display_ready <= i_display_enable;
      end else if (panel_type == LPM_PANEL_SHIFT2) begin
         o_panel_display_ready <= i_second_shift;
      end else begin
         o_panel_display_ready <= i_backplane_bias;
      end
   end

   // Power-save input and inverse-video input
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_power_save_req <= 1'b0;
         o_inverse_video <= 1'b0;
      end else begin
         o_power_save_req <= mode3_r[LPM_M3_PS_SEL] && io_in[LPM_IO_PS];
         o_inverse_video <= !is_tft && mode3_r[LPM_M3_INV_SEL] && io_in[LPM_IO_ELEVEN];
      end
   end

   // Power request; the level flop holds no async reset because its off level is strap dependent
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pwr_on_r <= 1'b0;
      end else begin
         pwr_on_r <= mode3_r[LPM_M3_PWR_ON] && !o_power_save_req;
      end
   end

   // Before capture the hard-wired strap gives the off level, loaded on each clock edge while reset is held
   always_ff @(posedge i_mclk) begin
      if (i_rst || !strap_valid) begin
         o_panel_power_control <= !i_config_straps[LPM_STRAP_POL];
      end else if (!pwr_on_r) begin
         o_panel_power_control <= !pwr_pol;
      end else begin
         o_panel_power_control <= pwr_pol;
      end
   end

   // Function override of each shared pin
   always_comb begin
      func_sel = '0;
      func_out = '0;
      func_oe = '0;
      func_sel[LPM_IO_PS] = mode3_r[LPM_M3_PS_SEL];
      func_sel[LPM_IO_MID_LSB +: LPM_PIX_MID_W] = {LPM_PIX_MID_W{is_tft}};
      func_out[LPM_IO_MID_LSB +: LPM_PIX_MID_W] = disp_on ? i_pixel_mid : '0;
      func_oe[LPM_IO_MID_LSB +: LPM_PIX_MID_W] = {LPM_PIX_MID_W{is_tft}};
      func_sel[LPM_IO_ELEVEN] = is_tft || mode3_r[LPM_M3_INV_SEL];
      func_out[LPM_IO_ELEVEN] = disp_on && i_pixel_eleven;
      func_oe[LPM_IO_ELEVEN] = is_tft;
   end

   generate
      for (genvar g = 0; g < LPM_IO_W; g++) begin : g_io
         lpm_io_bit u_bit (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .i_func_sel(func_sel[g]),
            .i_func_out(func_out[g]),
            .i_func_oe(func_oe[g]),
            .i_wr_dir(wr_dir),
            .i_wr_data(wr_data),
            .i_wdata_bit(i_reg_wdata[g]),
            .i_pad_in(i_io_pad_in[g]),
            .o_pad_out(o_io_pad_out[g]),
            .o_pad_oe(o_io_pad_oe[g]),
            .o_dir(io_dir[g]),
            .o_in(io_in[g])
         );
      end
   endgenerate

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   property p_read_low_byte;
      (o_bus_mode == LPM_BUS_GEN1) ##1 (o_bus_mode == LPM_BUS_GEN1) |-> o_low_byte_read_n == $past(i_read_pin);
   endproperty
   a_read_low_byte: assert property (p_read_low_byte) else $error("low byte read not following pin");

   property p_read_strobe1_idle;
      (o_bus_mode == LPM_BUS_STB1) |=> o_read_strobe_n && !o_bus_size_bit_one && o_low_byte_read_n;
   endproperty
   a_read_strobe1_idle: assert property (p_read_strobe1_idle) else $error("read pin used in strobe mode one");

   property p_ack_ready;
      (host_active && ack_style && i_core_ready) |=> (o_wait_oe && !o_wait_out);
   endproperty
   a_ack_ready: assert property (p_ack_ready) else $error("acknowledge not given when ready");

   property p_wait_request;
      (host_active && !ack_style && !i_core_ready) |=> (o_wait_oe && !o_wait_out);
   endproperty
   a_wait_request: assert property (p_wait_request) else $error("wait request missing");

   property p_wait_float;
      (i_cs_n || !strap_valid) |=> !o_wait_oe;
   endproperty
   a_wait_float: assert property (p_wait_float) else $error("wait pin driven without a cycle");

   property p_reserved_float;
      (o_bus_mode == LPM_BUS_RSVD) |=> !o_wait_oe;
   endproperty
   a_reserved_float: assert property (p_reserved_float) else $error("wait pin driven in reserved mode");

   property p_panel_quiet;
      !disp_on |=> (o_panel_pixel_bits_low == '0) && !o_panel_frame_pulse && !o_panel_line_pulse &&
                   !o_panel_shift_clock && !o_panel_display_ready;
   endproperty
   a_panel_quiet: assert property (p_panel_quiet) else $error("panel pins active while display off");

   property p_ready_tft;
      (disp_on && is_tft) |=> o_panel_display_ready == $past(i_display_enable);
   endproperty
   a_ready_tft: assert property (p_ready_tft) else $error("display enable not routed");

   property p_power_level;
      pwr_on_r |=> o_panel_power_control == $past(pwr_pol);
   endproperty
   a_power_level: assert property (p_power_level) else $error("power output at wrong level");

   property p_ps_input;
      mode3_r[LPM_M3_PS_SEL] |=> !o_io_pad_oe[LPM_IO_PS];
   endproperty
   a_ps_input: assert property (p_ps_input) else $error("power save pin driven");

   property p_mid_panel;
      is_tft |=> &o_io_pad_oe[LPM_IO_MID_LSB +: LPM_PIX_MID_W];
   endproperty
   a_mid_panel: assert property (p_mid_panel) else $error("mid pixel pins not driven for TFT");
endmodule
`default_nettype wire

// >>> lpm_board_model.sv
// Board model: shared pins pulled to the I/O supply when undriven, power-save pin level set by a switch
`default_nettype none
module lpm_board_model
   import lpm_pkg::*;
(
   input wire logic [LPM_IO_W-1:0] i_pad_out,
   input wire logic [LPM_IO_W-1:0] i_pad_oe,
   input wire logic i_ps_level,
   output logic [LPM_IO_W-1:0] o_pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Undriven pins read the pull level, never the last driven value
   always_comb begin
      o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & {{(LPM_IO_W-1){1'b1}}, i_ps_level});
   end
endmodule
`default_nettype wire

// >>> tb_lpm_pin_map.sv
// Self-checking testbench for the pin function map
`default_nettype none
module tb_lpm_pin_map
   import lpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [4:0] cnf; logic bs; lpm_bus_e mode;} lpm_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] straps = 5'h00;
   logic bs_n = 1'b1;
   logic cs_n = 1'b0;
   logic read_pin = 1'b1;
   logic core_ready = 1'b1;
   logic [7:0] pix_src = 8'hA5;
   logic [2:0] mid_src = 3'h5;
   logic ele_src = 1'b1;
   logic de = 1'b1;
   logic bias = 1'b0;
   logic sec = 1'b1;
   logic ps_level = 1'b1;
   logic [4:0] pad_in;
   logic [7:0] rdata;
   logic rs_n, lb_n, sz, wo, woe, be, fr, ln, sh, dr, pwr, inv, psr;
   lpm_bus_e mode;
   logic [7:0] pix;
   logic [4:0] pad_out, pad_oe;
   int n_errors = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   lpm_pin_map lpm_pin_map_inst (.i_mclk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_config_straps(straps), .i_bus_start_n(bs_n),
      .i_test_mode_enable(1'b0), .i_cs_n(cs_n), .i_read_pin(read_pin), .i_core_ready(core_ready),
      .o_read_strobe_n(rs_n), .o_low_byte_read_n(lb_n), .o_bus_size_bit_one(sz), .o_wait_out(wo),
      .o_wait_oe(woe), .o_bus_mode(mode), .o_big_endian(be), .i_pixel_low(pix_src), .i_pixel_mid(mid_src),
      .i_pixel_eleven(ele_src), .i_frame(1'b1), .i_line(1'b0), .i_shift(1'b1), .i_display_enable(de),
      .i_backplane_bias(bias), .i_second_shift(sec), .o_panel_pixel_bits_low(pix), .o_panel_frame_pulse(fr),
      .o_panel_line_pulse(ln), .o_panel_shift_clock(sh), .o_panel_display_ready(dr),
      .o_panel_power_control(pwr), .i_io_pad_in(pad_in), .o_io_pad_out(pad_out), .o_io_pad_oe(pad_oe),
      .o_inverse_video(inv), .o_power_save_req(psr));
   lpm_board_model lpm_board_model_inst (.i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ps_level(ps_level),
      .o_pad_in(pad_in));
   task automatic test_done();
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Straps change only while reset is held, as a hard-wired board would give
   task automatic do_reset(input logic [4:0] cnf, input logic bs);
      @(posedge clk);
      straps <= cnf;
      bs_n <= bs;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_clk(3);
   endtask
   initial begin
      #200000;
      n_errors++;
      test_done();
   end
   initial begin : main
      lpm_row_s rows[8];
      logic [7:0] d;
      lpm_bus_e m;
      logic ack;
      logic [3:0] drt;
      rows = '{'{5'h00, 1'b1, LPM_BUS_EMB2}, '{5'h19, 1'b1, LPM_BUS_EMB1}, '{5'h0B, 1'b1, LPM_BUS_STB1},
         '{5'h15, 1'b0, LPM_BUS_STB2}, '{5'h07, 1'b0, LPM_BUS_GEN1}, '{5'h1F, 1'b1, LPM_BUS_GEN2},
         '{5'h02, 1'b1, LPM_BUS_RSVD}, '{5'h06, 1'b0, LPM_BUS_RSVD}};
      wait_clk(2);
      check("rst_rdata", rdata, 8'h00);
      check("rst_strobes", {rs_n, lb_n, sz}, 3'b110);
      check("rst_wait", {wo, woe}, 2'b10);
      check("rst_mode", mode, LPM_BUS_RSVD);
      check("rst_pad_oe", pad_oe, 5'h00);
      check("rst_panel", {pix, fr, ln, sh, dr}, 12'h000);
      check("rst_power", pwr, 1'b1);
      foreach (rows[i]) begin
         do_reset(rows[i].cnf, rows[i].bs);
         m = rows[i].mode;
         check("bus_mode", mode, m);
         check("endian", be, rows[i].cnf[3]);
         check("power_off", pwr, !rows[i].cnf[4]);
         rd_reg(LPM_REG_STATUS, d);
         check("status", {d[7:6], d[4:0]}, {2'b10, rows[i].cnf[4:3], m});
         ack = (m == LPM_BUS_EMB2) || (m == LPM_BUS_STB1) || (m == LPM_BUS_STB2);
         for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            read_pin <= k[0];
            core_ready <= k[0];
            wait_clk(2);
            check("read_strobe", rs_n, (m inside {LPM_BUS_EMB1, LPM_BUS_EMB2, LPM_BUS_GEN2}) ? k[0] : 1'b1);
            check("low_byte", lb_n, (m == LPM_BUS_GEN1) ? k[0] : 1'b1);
            check("size_one", sz, (m == LPM_BUS_STB2) & k[0]);
            check("wait_oe", woe, m != LPM_BUS_RSVD);
            if (m != LPM_BUS_RSVD) begin
               check("wait_out", wo, ack ? !k[0] : k[0]);
            end
         end
         @(posedge clk);
         cs_n <= 1'b1;
         wait_clk(2);
         check("wait_idle", {woe, wo}, 2'b01);
         @(posedge clk);
         cs_n <= 1'b0;
      end
      do_reset(5'h1F, 1'b1);
      rd_reg(LPM_REG_MODE3, d);
      check("mode3_rst", d, LPM_MODE3_RST);
      wr_reg(8'hA7, 8'hFF);
      rd_reg(8'hA7, d);
      check("unmapped", d, 8'h00);
      wr_reg(LPM_REG_MODE3, 8'hFF);
      rd_reg(LPM_REG_MODE3, d);
      check("mode3_mask", d, LPM_MODE3_WMASK);
      wr_reg(LPM_REG_MODE3, 8'h52);
      wait_clk(3);
      check("pixel_low", pix, 8'hA5);
      check("pulses", {fr, ln, sh}, 3'b101);
      check("mid_oe", pad_oe[4:1], 4'hF);
      check("mid_out", pad_out[4:1], {ele_src, mid_src});
      check("power_on", pwr, 1'b1);
      drt = {bias, de, sec, bias};
      for (int t = 0; t < 4; t++) begin
         wr_reg(LPM_REG_MODE3, 8'h50 | t[7:0]);
         wait_clk(3);
         check("panel_display_ready", dr, drt[t]);
      end
      wr_reg(LPM_REG_MODE3, 8'h02);
      wait_clk(3);
      check("display_off", {pix, fr, ln, sh, dr, pad_out[4:1]}, 16'h0000);
      wr_reg(LPM_REG_MODE3, 8'h00);
      wr_reg(LPM_REG_IO_DIR, 8'h1E);
      wr_reg(LPM_REG_IO_DATA, 8'h0A);
      wait_clk(3);
      check("io_oe", pad_oe, 5'h1E);
      check("io_out", pad_out & pad_oe, 5'h0A);
      rd_reg(LPM_REG_IO_DATA, d);
      check("io_in", d, 8'h0B);
      wr_reg(LPM_REG_IO_DIR, 8'h1F);
      wr_reg(LPM_REG_MODE3, 8'h44);
      wait_clk(5);
      check("ps_oe", pad_oe[0], 1'b0);
      check("ps_req", {psr, pwr}, 2'b10);
      @(posedge clk);
      ps_level <= 1'b0;
      wait_clk(4);
      check("ps_clear", {psr, pwr}, 2'b01);
      wr_reg(LPM_REG_MODE3, 8'h20);
      wait_clk(3);
      check("inv_sel", {pad_oe[4], inv}, 2'b01);
      @(posedge clk);
      rst <= 1'b1;
      wait_clk(1);
      check("mid_reset", {pad_oe, woe, dr, inv, psr, pwr}, 10'h000);
      @(posedge clk);
      rst <= 1'b0;
      test_done();
   end
endmodule
`default_nettype wire
